// ### src/ide_decode_pkg.sv
/*
 * Package for the drive-select decode block: address constants, reset values
 * and the packed carriers for host bus inputs and decode outputs.
 * Assumes a ten-bit host I/O address and active-low host strobes.
 */
`default_nettype none

package ide_decode_pkg;

	// Address width of the host I/O bus
	localparam int unsigned ADDR_W = 10;

	// Command block base (eight locations); low three bits ignored
	localparam logic [9:0] CMD_BLOCK_BASE  = 10'h1F0;
	// Control block pair base (two locations); low bit ignored
	localparam logic [9:0] CTRL_BLOCK_BASE = 10'h3F6;
	// Control block address whose bit 7 belongs to the floppy side
	localparam logic [9:0] FLOPPY_SHARED_ADDR = 10'h3F7;

	// Reset values of all active-low outputs: inactive
	localparam logic OUT_RESET_N = 1'b1;

	// Synchroniser depth for pin inputs
	localparam int unsigned SYNC_STAGES = 2;

	// Host bus pins as seen after synchronisation
	typedef struct packed {
		logic [9:0] addr;       // I/O address
		logic       aen;        // Address enable, high during DMA
		logic       rd_n;       // Read strobe, active low
		logic       wr_n;       // Write strobe, active low
		logic       io16_n;     // Drive 16-bit indication, active low
	} host_bus_t;

	// Idle bus held by the synchroniser in reset: no address, DMA owner,
	// strobes and 16-bit indication all released
	localparam host_bus_t HOST_BUS_RESET = '{
		addr:   10'h000,
		aen:    1'b1,
		rd_n:   1'b1,
		wr_n:   1'b1,
		io16_n: 1'b1
	};

	// Decoded enables, all active low
	typedef struct packed {
		logic cmd_block_select_n;
		logic ctrl_block_select_n;
		logic low_byte_xcvr_enable_n;
		logic high_byte_xcvr_enable_n;
		logic bit7_lane_enable_n;
	} decode_out_t;

endpackage : ide_decode_pkg

`default_nettype wire

// ### src/pin_sync.sv
/*
 * Two-flop synchroniser, parameterised in width.
 * Assumes the input is asynchronous to core_clk_i; the first stage is read only by the second.
 */
`default_nettype none

module pin_sync #(
	parameter int unsigned WIDTH = 1,        // Bits synchronised
	parameter logic [WIDTH-1:0] RST_VAL = '0 // Value held in reset
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             srst_i,
	// Data
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta;      // First stage, metastable-prone
	logic [WIDTH-1:0] next_meta; // Next first stage
	logic [WIDTH-1:0] next_sync; // Next second stage

	// Next values: reset constant or shift
	always_comb begin
		next_meta = srst_i ? RST_VAL : async_i;
		next_sync = srst_i ? RST_VAL : meta;
	end

	// Register both stages
	always_ff @(posedge core_clk_i) begin
		meta   <= next_meta;
		sync_o <= next_sync;
	end

endmodule : pin_sync

`default_nettype wire

// ### src/ide_select_decode.sv
/*
 * Host-address decode for the hard-drive header: two chip selects and three
 * buffer enables, registered so every output comes from a flip-flop.
 * Assumes host pins are asynchronous (synchronised here) and that the strobes
 * are held long enough to cover the three-cycle latency at 200 MHz.
 * DMA cycles are not decoded: AEN high keeps every output inactive.
 */
// Contract
// - Command select low for addresses 1F0-1F7
// - Control select low for 3F6 or 3F7
// - Low enable: all but writes to 3F7
// - High enable: strobe at 1F0-1F7 with 16-bit
// - Bit-7 lane on reads 1F0-1F7, 3F6 only
// - Bit-7 lane on writes 1F0-1F7, 3F6 only
// - Bit 7 at 3F7 left to floppy
`default_nettype none

module ide_select_decode (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       srst_i,
	// Host I/O bus pins
	input  wire logic [9:0] host_addr_i,
	input  wire logic       host_aen_i,
	input  wire logic       host_rd_n_i,
	input  wire logic       host_wr_n_i,
	// Drive 16-bit indication
	input  wire logic       io16_n_i,
	// Drive selects
	output logic            cmd_block_select_n_o,
	output logic            ctrl_block_select_n_o,
	// Transceiver enables
	output logic            low_byte_xcvr_enable_n_o,
	output logic            high_byte_xcvr_enable_n_o,
	output logic            bit7_lane_enable_n_o
);

	ide_decode_pkg::host_bus_t   raw_bus;  // Pins gathered
	ide_decode_pkg::host_bus_t   bus;      // Pins after two flops
	ide_decode_pkg::decode_out_t next_out; // Decoded values
	ide_decode_pkg::decode_out_t out_q;    // Registered outputs

	logic in_cmd;     // Address in command block
	logic in_ctrl;    // Address in control pair
	logic rd;         // Read strobe active
	logic wr;         // Write strobe active
	logic a0;         // Low address bit

	assign raw_bus = '{addr: host_addr_i, aen: host_aen_i, rd_n: host_rd_n_i,
	                   wr_n: host_wr_n_i, io16_n: io16_n_i};

	// Pins cross into core clock; reset to idle bus with AEN high.
	// Address and strobes are synchronised bit by bit, so a change that
	// lands on an edge may skew by one cycle; the strobes must stand
	// longer than that for a clean decode.
	pin_sync #(
		.WIDTH   ($bits(ide_decode_pkg::host_bus_t)),
		.RST_VAL (ide_decode_pkg::HOST_BUS_RESET)
	) u_sync (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.async_i    (raw_bus),
		.sync_o     (bus)
	);

	// Decode of the synchronised bus
	always_comb begin
		in_cmd  = !bus.aen && (bus.addr[9:3] == ide_decode_pkg::CMD_BLOCK_BASE[9:3]);
		in_ctrl = !bus.aen && (bus.addr[9:1] == ide_decode_pkg::CTRL_BLOCK_BASE[9:1]);
		// Strobes and A0 named once for the lane terms below
		rd      = !bus.rd_n;
		wr      = !bus.wr_n;
		a0      = bus.addr[0];
		next_out.cmd_block_select_n  = !in_cmd;
		next_out.ctrl_block_select_n = !in_ctrl;
		// Writes to 3F7 excluded: no drive register behind it
		next_out.low_byte_xcvr_enable_n =
			!((in_cmd && (rd || wr)) || (in_ctrl && ((wr && !a0) || rd)));
		// Upper lane only for 16-bit data phases in the command block
		next_out.high_byte_xcvr_enable_n = !(!bus.io16_n && in_cmd && (rd || wr));
		// Bit 7 at 3F7 belongs to floppy, so the lane stays off there
		next_out.bit7_lane_enable_n =
			!((rd && (in_cmd || (in_ctrl && !a0)))
			|| (wr && (in_cmd || (in_ctrl && !a0))));
		// Reset forces every output inactive
		if (srst_i) begin
			next_out = '{default: ide_decode_pkg::OUT_RESET_N};
		end
	end

	// Output register: every pin comes from a flop, so decode hazards on
	// address edges never reach the drive selects as glitches
	always_ff @(posedge core_clk_i) begin
		out_q <= next_out;
	end

	assign cmd_block_select_n_o      = out_q.cmd_block_select_n;
	assign ctrl_block_select_n_o     = out_q.ctrl_block_select_n;
	assign low_byte_xcvr_enable_n_o  = out_q.low_byte_xcvr_enable_n;
	assign high_byte_xcvr_enable_n_o = out_q.high_byte_xcvr_enable_n;
	assign bit7_lane_enable_n_o      = out_q.bit7_lane_enable_n;

	// Checks against the synchronised bus one cycle earlier: the output
	// register adds exactly one edge, so $past of the bus lines up with
	// the outputs sampled now. Reset blanks every check; the sync stages
	// then hold an idle bus with AEN high, so nothing decodes on release.
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	// Command block address with AEN low must pull the command select
	AST_CMD_SEL: assert property (
		!$past(bus.aen) && $past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|-> !cmd_block_select_n_o
	) else $error("command select missed");

	// Any other address leaves the command select high
	AST_CMD_IDLE: assert property (
		$past(bus.addr[9:3]) != ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|-> cmd_block_select_n_o
	) else $error("command select false hit");

	// Control pair address with AEN low must pull the control select
	AST_CTRL_SEL: assert property (
		!$past(bus.aen) && $past(bus.addr[9:1]) == ide_decode_pkg::CTRL_BLOCK_BASE[9:1]
		|-> !ctrl_block_select_n_o
	) else $error("control select missed");

	// Any address outside the pair leaves the control select high
	AST_CTRL_IDLE: assert property (
		$past(bus.addr[9:1]) != ide_decode_pkg::CTRL_BLOCK_BASE[9:1]
		|-> ctrl_block_select_n_o
	) else $error("control select false hit");

	// AEN high (DMA) blocks every select and enable
	AST_DMA_QUIET: assert property (
		$past(bus.aen) && !$past(srst_i)
		|-> cmd_block_select_n_o && ctrl_block_select_n_o && low_byte_xcvr_enable_n_o
		&& high_byte_xcvr_enable_n_o && bit7_lane_enable_n_o
	) else $error("select during AEN high");

	// No drive register sits behind a write to 3F7
	AST_LOW_3F7_WR: assert property (
		$past(bus.addr) == ide_decode_pkg::FLOPPY_SHARED_ADDR && $past(bus.rd_n)
		|-> low_byte_xcvr_enable_n_o
	) else $error("low lane on 3F7 write");

	// Reads in the command block or the control pair open the low lane
	AST_LOW_RD: assert property (
		!$past(bus.aen) && !$past(bus.rd_n)
		&& ($past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|| $past(bus.addr[9:1]) == ide_decode_pkg::CTRL_BLOCK_BASE[9:1])
		|-> !low_byte_xcvr_enable_n_o
	) else $error("low lane missed on read");

	// Writes in the command block or to 3F6 open the low lane
	AST_LOW_WR: assert property (
		!$past(bus.aen) && !$past(bus.wr_n)
		&& ($past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|| $past(bus.addr) == ide_decode_pkg::CTRL_BLOCK_BASE)
		|-> !low_byte_xcvr_enable_n_o
	) else $error("low lane missed on write");

	// No strobe, no low lane
	AST_LOW_IDLE: assert property (
		$past(bus.rd_n) && $past(bus.wr_n)
		|-> low_byte_xcvr_enable_n_o
	) else $error("low lane without strobe");

	// Upper lane only with the 16-bit indication and the command select
	AST_HIGH: assert property (
		!high_byte_xcvr_enable_n_o
		|-> !$past(bus.io16_n) && !cmd_block_select_n_o
	) else $error("high lane without 16-bit");

	// A 16-bit strobe in the command block opens the upper lane
	AST_HIGH_ON: assert property (
		!$past(bus.aen) && !$past(bus.io16_n) && !($past(bus.rd_n) && $past(bus.wr_n))
		&& $past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|-> !high_byte_xcvr_enable_n_o
	) else $error("high lane missed on 16-bit transfer");

	// Reads of 3F6 carry bit 7 from the drive
	AST_B7_RD: assert property (
		!$past(bus.aen) && !$past(bus.rd_n) && $past(bus.addr) == ide_decode_pkg::CTRL_BLOCK_BASE
		|-> !bit7_lane_enable_n_o
	) else $error("bit7 lane missed on 3F6 read");

	// Reads in the command block carry bit 7 from the drive
	AST_B7_RD_CMD: assert property (
		!$past(bus.aen) && !$past(bus.rd_n)
		&& $past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|-> !bit7_lane_enable_n_o
	) else $error("bit7 lane missed on command read");

	// Writes in the command block carry bit 7 to the drive
	AST_B7_WR: assert property (
		!$past(bus.aen) && !$past(bus.wr_n) && $past(bus.addr[9:3]) == ide_decode_pkg::CMD_BLOCK_BASE[9:3]
		|-> !bit7_lane_enable_n_o
	) else $error("bit7 lane missed on write");

	// Writes to 3F6 carry bit 7 to the drive
	AST_B7_WR_3F6: assert property (
		!$past(bus.aen) && !$past(bus.wr_n) && $past(bus.addr) == ide_decode_pkg::CTRL_BLOCK_BASE
		|-> !bit7_lane_enable_n_o
	) else $error("bit7 lane missed on 3F6 write");

	// Bit 7 at 3F7 is the floppy side's, read or write
	AST_B7_3F7: assert property (
		$past(bus.addr) == ide_decode_pkg::FLOPPY_SHARED_ADDR
		|-> bit7_lane_enable_n_o
	) else $error("bit7 lane driven at 3F7");

	// No strobe, no bit-7 lane
	AST_B7_IDLE: assert property (
		$past(bus.rd_n) && $past(bus.wr_n)
		|-> bit7_lane_enable_n_o
	) else $error("bit7 lane without strobe");

	// Main traffic shapes: 16-bit data phase, 8-bit command access,
	// control reads and writes, and the floppy-shared read at 3F7
	COV_CMD_RD16: cover property (!high_byte_xcvr_enable_n_o);
	COV_CMD_WR8: cover property (!cmd_block_select_n_o && !low_byte_xcvr_enable_n_o && high_byte_xcvr_enable_n_o);
	COV_CTRL_RD: cover property (!ctrl_block_select_n_o && !low_byte_xcvr_enable_n_o);
	COV_3F6_WR: cover property (!ctrl_block_select_n_o && !bit7_lane_enable_n_o);
	COV_3F7_RD: cover property (!low_byte_xcvr_enable_n_o && bit7_lane_enable_n_o);

endmodule : ide_select_decode

`default_nettype wire

// ### tb/drive_model.sv
/*
 * Behavioural hard drive: answers the 16-bit indication.
 * Assumes the select comes straight from the decode block.
 */
`default_nettype none

module drive_model (
	// Select and transfer width
	input  wire logic sel_n_i,
	input  wire logic wide_i,
	// Line held low regardless of select, to probe the decode
	input  wire logic stuck_i,
	// 16-bit indication
	output logic      io16_n_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Open-collector line: the pull-up shows unless the drive is selected with wide_i set, or stuck_i holds it low
	assign io16_n_o = ~((~sel_n_i & wide_i) | stuck_i);
endmodule : drive_model

`default_nettype wire

// ### tb/ide_select_decode_tb.sv
/*
 * Self-checking bench for the drive-select decode block.
 * Assumes every output settles within eight cycles of a pin change, drive reply included.
 */
`default_nettype none

module ide_select_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk, srst, aen, rd_n, wr_n, wide, stuck; // Bench-driven pins
	logic       io16_n;                           // From the drive model
	logic [9:0] addr;                             // Host address
	logic [4:0] o;                                // Selects and enables, as seen
	int         bad_count, checked;               // Tallies

	drive_model u_drv (.sel_n_i(o[4]), .wide_i(wide), .stuck_i(stuck), .io16_n_o(io16_n));
	ide_select_decode dut (.core_clk_i(clk), .srst_i(srst), .host_addr_i(addr),
		.host_aen_i(aen), .host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .io16_n_i(io16_n),
		.cmd_block_select_n_o(o[4]), .ctrl_block_select_n_o(o[3]), .low_byte_xcvr_enable_n_o(o[2]),
		.high_byte_xcvr_enable_n_o(o[1]), .bit7_lane_enable_n_o(o[0]));
	// Verdict
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// Single comparison point
	task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Outputs worked out from address, AEN, strobes and drive width
	function automatic logic [4:0] exp_out(input logic [9:0] a, input logic e, r, w, x);
		logic c, k, s;
		c = !e && a[9:3] == 7'h3E;
		k = !e && a[9:1] == 9'h1FB;
		s = !r || !w;
		return ~{c, k, (c & s) | (k & (!r | (!w & !a[0]))), c & s & x, (c | (k & !a[0])) & s};
	endfunction : exp_out

	// Apply pins, let both the decode and the drive reply settle, then compare
	task automatic step(input logic [9:0] a, input logic e, r, w, x);
		@(negedge clk);
		addr = a;
		aen  = e;
		rd_n = r;
		wr_n = w;
		wide = x;
		repeat (8) @(negedge clk);
		chk(o, exp_out(a, e, r, w, x));
	endtask : step

	// Command block and both neighbours, idle, read, write, 8 and 16 bit
	task automatic t_cmd_block();
		for (int i = 'h1EF; i <= 'h1F8; i++)
			for (int op = 0; op < 3; op++)
				for (int x = 0; x < 2; x++) step(10'(i), 1'b0, op != 1, op != 2, x[0]);
	endtask : t_cmd_block

	// Control pair and neighbours; bit 7 must stay off at the shared address
	task automatic t_ctrl_block();
		for (int i = 'h3F4; i <= 'h3F8; i++)
			for (int op = 0; op < 3; op++) step(10'(i), 1'b0, op != 1, op != 2, 1'b1);
	endtask : t_ctrl_block

	// DMA cycles and upper-bit aliases must not decode
	task automatic t_full_decode();
		step(10'h1F0, 1'b1, 1'b0, 1'b1, 1'b1);
		step(10'h3F6, 1'b1, 1'b1, 1'b0, 1'b1);
		step(10'h3F0, 1'b0, 1'b0, 1'b1, 1'b1);
		step(10'h0F6, 1'b0, 1'b0, 1'b1, 1'b1);
		step(10'h2F7, 1'b0, 1'b1, 1'b0, 1'b1);
	endtask : t_full_decode

	// Drive claiming 16 bits outside the command block must not open the upper lane
	task automatic t_wide_outside();
		stuck = 1'b1;
		step(10'h3F6, 1'b0, 1'b0, 1'b1, 1'b1);
		step(10'h3F6, 1'b0, 1'b1, 1'b0, 1'b1);
		step(10'h3F7, 1'b0, 1'b0, 1'b1, 1'b1);
		step(10'h1F0, 1'b1, 1'b0, 1'b1, 1'b1);
		stuck = 1'b0;
	endtask : t_wide_outside

	// Reset in mid-transfer drops every output, which stay idle one edge past release
	task automatic t_mid_reset();
		step(10'h1F0, 1'b0, 1'b0, 1'b1, 1'b1);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		chk(o, 5'h1F);
		srst = 1'b0;
		@(negedge clk);
		chk(o, 5'h1F);
		step(10'h1F0, 1'b0, 1'b0, 1'b1, 1'b1);
	endtask : t_mid_reset

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Main sequence
	initial begin
		bad_count = 0;
		checked   = 0;
		srst = 1'b1;
		addr = 10'h000;
		aen  = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		wide = 1'b0;
		stuck = 1'b0;
		repeat (10) @(negedge clk);
		chk(o, 5'h1F); // Everything inactive while held in reset
		srst = 1'b0;
		t_cmd_block();
		t_ctrl_block();
		t_full_decode();
		t_wide_outside();
		t_mid_reset();
		end_sim();
	end
endmodule : ide_select_decode_tb

`default_nettype wire
